/* inc/can_regs_pkg.sv */
// Register map and field layout of the CAN mask, mailbox and timer slice.
// Assumes one system clock and byte-wide special function register accesses.
package can_regs_pkg;
  localparam logic [7:0] ADDR_TIMER_PRESCALE = 8'ha1;
  localparam logic [7:0] ADDR_MAILBOX_DATA = 8'ha3;
  localparam logic [7:0] ADDR_TRIG_CAP_LOW = 8'ha4;
  localparam logic [7:0] ADDR_TRIG_CAP_HIGH = 8'ha5;
  localparam logic [7:0] ADDR_MSG_TIMER_LOW = 8'hac;
  localparam logic [7:0] ADDR_MSG_TIMER_HIGH = 8'had;
  localparam logic [7:0] ADDR_STAMP_LOW = 8'hae;
  localparam logic [7:0] ADDR_STAMP_HIGH = 8'haf;
  localparam logic [7:0] ADDR_ID_MASK_TOP = 8'hc4;
  localparam logic [7:0] ADDR_ID_MASK_MID_HIGH = 8'hc5;
  localparam logic [7:0] ADDR_ID_MASK_MID_LOW = 8'hc6;
  localparam logic [7:0] ADDR_ID_MASK_LOW_FLAGS = 8'hc7;
  localparam int BIT_REMOTE_REQ_MASK = 2;
  localparam int BIT_RESERVED_MASK = 1;
  localparam int BIT_EXT_FLAG_MASK = 0;
  localparam int ID_LOW_LSB = 3;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam int MAILBOX_BYTES = 8;
  localparam int OBJECT_COUNT = 15;
  localparam int ID_BITS = 29;
  localparam int CAN_CLK_PRE_DIV = 1;
endpackage

/* logic/can_accept_filter.sv */
// Acceptance comparison of one received frame against one message object.
// Assumes mask and tag bits are stable while the received fields are presented.
`timescale 1ns/1ps
`default_nettype none
module can_accept_filter (
  // Object settings
  input wire logic [can_regs_pkg::ID_BITS-1:0] idMaskBits,
  input wire logic [can_regs_pkg::ID_BITS-1:0] idTagBits,
  input wire logic remoteReqMask,
  input wire logic remoteReqTag,
  input wire logic extFlagMask,
  input wire logic extFlagTag,
  // Received fields
  input wire logic [can_regs_pkg::ID_BITS-1:0] rxId,
  input wire logic rxRemoteReq,
  input wire logic rxExtFlag,
  // Result
  output logic hit
);
  import can_regs_pkg::*;
  logic [ID_BITS-1:0] bitOk;
  genvar i;
  generate
    for (i = 0; i < ID_BITS; i++) begin : g_bit
      assign bitOk[i] = !idMaskBits[i] || (rxId[i] == idTagBits[i]);
    end
  endgenerate
  logic rtrOk;
  logic ideOk;
  assign rtrOk = !remoteReqMask || (rxRemoteReq == remoteReqTag);
  assign ideOk = !extFlagMask || (rxExtFlag == extFlagTag);
  assign hit = (&bitOk) && rtrOk && ideOk;
endmodule
`default_nettype wire

/* logic/can_mask_mailbox_timers.sv */
// CAN register slice: acceptance mask, mailbox byte port, timer prescaler,
// message timer, time stamp and time-triggered capture, all reached by SFR.
// Assumes the frame engine supplies object select, received fields and events.
`timescale 1ns/1ps
`default_nettype none
module can_mask_mailbox_timers #(
  parameter int OBJECTS = can_regs_pkg::OBJECT_COUNT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Special function register access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // Page selection, from the page register outside
  input wire logic [3:0] pageObject,
  input wire logic [2:0] pageIndex,
  input wire logic pageWrite,
  input wire logic autoIncEnable,
  // Tag fields of the selected object
  input wire logic [can_regs_pkg::ID_BITS-1:0] idTagBits,
  input wire logic remoteReqTag,
  input wire logic extFlagTag,
  // Frame engine side
  input wire logic [can_regs_pkg::ID_BITS-1:0] rxId,
  input wire logic rxRemoteReq,
  input wire logic rxExtFlag,
  input wire logic frameIsRx,
  input wire logic stampStrobe,
  input wire logic trigStrobe,
  output logic accept,
  output logic [2:0] bytePointer,
  output logic timerTick
);
  import can_regs_pkg::*;

  // Object select is four bits wide, so sixteen objects at most
  if (OBJECTS < 1 || OBJECTS > 16) begin : g_bad_objects
    $error("OBJECTS must be 1 to 16");
  end

  // Register storage; mask, stamp and mailbox storage deliberately unreset
  logic [ID_BITS-1:0] idMaskBits_reg;
  logic remoteReqMask_reg;
  logic extFlagMask_reg;
  logic [7:0] timerDivisor_reg;
  logic [7:0] preCount_reg;
  logic [15:0] messageTimerCount_reg;
  logic [15:0] stampValue_reg [OBJECTS];
  logic [15:0] trigCaptureValue_reg;
  logic [7:0] mailboxByte_reg [OBJECTS][MAILBOX_BYTES];
  logic [2:0] bytePtr_reg;
  logic [3:0] objSel;
  logic dataAccess;
  logic filterHit;

  assign objSel = (32'(pageObject) < OBJECTS) ? pageObject : 4'h0;
  assign dataAccess = (sfrWrite || sfrRead) && (sfrAddr == ADDR_MAILBOX_DATA);

  // Mask registers: no reset branch, software programs them first
  always_ff @(posedge core_clk) begin
    if (sfrWrite) begin
      case (sfrAddr)
        ADDR_ID_MASK_TOP: idMaskBits_reg[28:21] <= sfrWdata;
        ADDR_ID_MASK_MID_HIGH: idMaskBits_reg[20:13] <= sfrWdata;
        ADDR_ID_MASK_MID_LOW: idMaskBits_reg[12:5] <= sfrWdata;
        ADDR_ID_MASK_LOW_FLAGS: begin
          idMaskBits_reg[4:0] <= sfrWdata[7:ID_LOW_LSB];
          remoteReqMask_reg <= sfrWdata[BIT_REMOTE_REQ_MASK];
          extFlagMask_reg <= sfrWdata[BIT_EXT_FLAG_MASK];
        end
        default: begin
        end
      endcase
    end
  end

  // Prescaler register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerDivisor_reg <= PRESCALE_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_TIMER_PRESCALE) begin
      timerDivisor_reg <= sfrWdata;
    end
  end

  // Prescaler: tick once every divisor+1 clocks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      preCount_reg <= 8'h00;
    end else if (preCount_reg >= timerDivisor_reg) begin
      preCount_reg <= 8'h00;
    end else begin
      preCount_reg <= preCount_reg + 8'h01;
    end
  end
  assign timerTick = (preCount_reg >= timerDivisor_reg);

  // Message timer, read-only to software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      messageTimerCount_reg <= TIMER_RESET;
    end else if (timerTick) begin
      messageTimerCount_reg <= messageTimerCount_reg + 16'h0001;
    end
  end

  // Capture of the running timer at a time-triggered event
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trigCaptureValue_reg <= TIMER_RESET;
    end else if (trigStrobe) begin
      trigCaptureValue_reg <= messageTimerCount_reg;
    end
  end

  // Per-object stamps, undefined until the first frame
  always_ff @(posedge core_clk) begin
    if (stampStrobe) begin
      stampValue_reg[objSel] <= messageTimerCount_reg;
    end
  end

  // Mailbox byte pointer, loaded by page write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bytePtr_reg <= 3'h0;
    end else if (pageWrite) begin
      bytePtr_reg <= pageIndex;
    end else if (dataAccess && autoIncEnable) begin
      bytePtr_reg <= bytePtr_reg + 3'h1;
    end
  end
  assign bytePointer = bytePtr_reg;

  // Mailbox storage; no reset, contents come only from software writes
  always_ff @(posedge core_clk) begin
    if (sfrWrite && sfrAddr == ADDR_MAILBOX_DATA) begin
      mailboxByte_reg[objSel][bytePtr_reg] <= sfrWdata;
    end
  end

  // Read decode; unmapped addresses answer zero with no hit
  always_comb begin
    sfrRdata = 8'h00;
    sfrHit = 1'b1;
    case (sfrAddr)
      ADDR_TIMER_PRESCALE: sfrRdata = timerDivisor_reg;
      ADDR_MAILBOX_DATA: sfrRdata = mailboxByte_reg[objSel][bytePtr_reg];
      ADDR_TRIG_CAP_LOW: sfrRdata = trigCaptureValue_reg[7:0];
      ADDR_TRIG_CAP_HIGH: sfrRdata = trigCaptureValue_reg[15:8];
      ADDR_MSG_TIMER_LOW: sfrRdata = messageTimerCount_reg[7:0];
      ADDR_MSG_TIMER_HIGH: sfrRdata = messageTimerCount_reg[15:8];
      ADDR_STAMP_LOW: sfrRdata = stampValue_reg[objSel][7:0];
      ADDR_STAMP_HIGH: sfrRdata = stampValue_reg[objSel][15:8];
      ADDR_ID_MASK_TOP: sfrRdata = idMaskBits_reg[28:21];
      ADDR_ID_MASK_MID_HIGH: sfrRdata = idMaskBits_reg[20:13];
      ADDR_ID_MASK_MID_LOW: sfrRdata = idMaskBits_reg[12:5];
      ADDR_ID_MASK_LOW_FLAGS: begin
        // Reserved bit reads zero here, a legal choice of an undefined value
        sfrRdata = {idMaskBits_reg[4:0], remoteReqMask_reg, 1'b0, extFlagMask_reg};
      end
      default: sfrHit = 1'b0;
    endcase
  end

  can_accept_filter u_filter (
    .idMaskBits(idMaskBits_reg),
    .idTagBits(idTagBits),
    .remoteReqMask(remoteReqMask_reg),
    .remoteReqTag(remoteReqTag),
    .extFlagMask(extFlagMask_reg),
    .extFlagTag(extFlagTag),
    .rxId(rxId),
    .rxRemoteReq(rxRemoteReq),
    .rxExtFlag(rxExtFlag),
    .hit(filterHit)
  );

  // Transmit frames never consult the mask
  assign accept = frameIsRx && filterHit;

  // Assertions
  property p_tick_period;
    @(posedge core_clk) disable iff (!resetn)
    (timerTick && timerDivisor_reg == 8'h03) ##1 (timerDivisor_reg == 8'h03) [*4]
      |-> timerTick && !$past(timerTick) && !$past(timerTick, 2) && !$past(timerTick, 3);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("prescale period wrong");

  property p_timer_step;
    @(posedge core_clk) disable iff (!resetn)
    timerTick |=> messageTimerCount_reg == $past(messageTimerCount_reg) + 16'h0001;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not step");

  property p_timer_hold;
    @(posedge core_clk) disable iff (!resetn)
    !timerTick |=> $stable(messageTimerCount_reg);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved without tick");

  property p_capture;
    @(posedge core_clk) disable iff (!resetn)
    trigStrobe |=> trigCaptureValue_reg == $past(messageTimerCount_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture mismatch");

  property p_ptr_inc;
    @(posedge core_clk) disable iff (!resetn)
    (dataAccess && autoIncEnable && !pageWrite) |=> bytePtr_reg == $past(bytePtr_reg) + 3'h1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");

  property p_ptr_wrap;
    @(posedge core_clk) disable iff (!resetn)
    (bytePtr_reg == 3'h7 && dataAccess && autoIncEnable && !pageWrite) |=> bytePtr_reg == 3'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_page_load;
    @(posedge core_clk) disable iff (!resetn)
    pageWrite |=> bytePtr_reg == $past(pageIndex);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page index not taken");

  property p_no_tx_accept;
    @(posedge core_clk) disable iff (!resetn)
    !frameIsRx |-> !accept;
  endproperty
  a_no_tx_accept: assert property (p_no_tx_accept) else $error("mask used on transmit");

  property p_open_mask;
    @(posedge core_clk) disable iff (!resetn)
    (frameIsRx && idMaskBits_reg == '0 && !remoteReqMask_reg && !extFlagMask_reg) |-> accept;
  endproperty
  a_open_mask: assert property (p_open_mask) else $error("open mask refused frame");

  property p_ide_check;
    @(posedge core_clk) disable iff (!resetn)
    (frameIsRx && extFlagMask_reg && rxExtFlag != extFlagTag) |-> !accept;
  endproperty
  a_ide_check: assert property (p_ide_check) else $error("extension mismatch accepted");

  property p_rtr_check;
    @(posedge core_clk) disable iff (!resetn)
    (frameIsRx && remoteReqMask_reg && rxRemoteReq != remoteReqTag) |-> !accept;
  endproperty
  a_rtr_check: assert property (p_rtr_check) else $error("remote mismatch accepted");

  property p_pre_wrap;
    @(posedge core_clk) disable iff (!resetn)
    timerTick |=> preCount_reg == 8'h00;
  endproperty
  a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not restart");

  property p_pre_count;
    @(posedge core_clk) disable iff (!resetn)
    !timerTick |=> preCount_reg == $past(preCount_reg) + 8'h01;
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("prescaler did not count");

  property p_prescale_write;
    @(posedge core_clk) disable iff (!resetn)
    (sfrWrite && sfrAddr == ADDR_TIMER_PRESCALE) |=> timerDivisor_reg == $past(sfrWdata);
  endproperty
  a_prescale_write: assert property (p_prescale_write) else $error("divisor lost");

  // Reset checks carry no disable, they look inside reset itself
  property p_prescale_reset;
    @(posedge core_clk)
    !resetn |-> timerDivisor_reg == PRESCALE_RESET;
  endproperty
  a_prescale_reset: assert property (p_prescale_reset) else $error("divisor reset");

  property p_timer_reset;
    @(posedge core_clk)
    !resetn |-> messageTimerCount_reg == TIMER_RESET;
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("timer not reset");

  property p_capture_reset;
    @(posedge core_clk)
    !resetn |-> trigCaptureValue_reg == TIMER_RESET;
  endproperty
  a_capture_reset: assert property (p_capture_reset) else $error("capture not reset");

  property p_capture_hold;
    @(posedge core_clk) disable iff (!resetn)
    !trigStrobe |=> $stable(trigCaptureValue_reg);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture moved");

  property p_stamp;
    @(posedge core_clk) disable iff (!resetn)
    stampStrobe ##1 $stable(objSel) |-> stampValue_reg[objSel] == $past(messageTimerCount_reg);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp mismatch");

  property p_ptr_hold;
    @(posedge core_clk) disable iff (!resetn)
    (!pageWrite && !(dataAccess && autoIncEnable)) |=> $stable(bytePtr_reg);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

  property p_id_check;
    @(posedge core_clk) disable iff (!resetn)
    (frameIsRx && ((rxId ^ idTagBits) & idMaskBits_reg) != '0) |-> !accept;
  endproperty
  a_id_check: assert property (p_id_check) else $error("id mismatch accepted");

  property p_match_accept;
    @(posedge core_clk) disable iff (!resetn)
    (frameIsRx && ((rxId ^ idTagBits) & idMaskBits_reg) == '0
      && (!remoteReqMask_reg || rxRemoteReq == remoteReqTag)
      && (!extFlagMask_reg || rxExtFlag == extFlagTag)) |-> accept;
  endproperty
  a_match_accept: assert property (p_match_accept) else $error("match refused");

  property p_mask_top_write;
    @(posedge core_clk) disable iff (!resetn)
    (sfrWrite && sfrAddr == ADDR_ID_MASK_TOP) |=> idMaskBits_reg[28:21] == $past(sfrWdata);
  endproperty
  a_mask_top_write: assert property (p_mask_top_write) else $error("top mask lost");

  property p_mask_flags_write;
    @(posedge core_clk) disable iff (!resetn)
    (sfrWrite && sfrAddr == ADDR_ID_MASK_LOW_FLAGS) |=>
      {idMaskBits_reg[4:0], remoteReqMask_reg, 1'b0, extFlagMask_reg}
      == ($past(sfrWdata) & 8'hfd);
  endproperty
  a_mask_flags_write: assert property (p_mask_flags_write) else $error("flags lost");
endmodule
`default_nettype wire

/* verif/sfr_host_model.sv */
// Processor core model: byte-wide special function register reads and writes.
// Assumes the slice answers reads combinationally and takes writes on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  // Clock
  input wire logic core_clk,
  // Register access
  output logic [7:0] sfrAddr,
  output logic sfrWrite,
  output logic sfrRead,
  output logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata
);
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    // Reserved mask bit is always sent as zero
    sfrWdata = (a == can_regs_pkg::ADDR_ID_MASK_LOW_FLAGS) ? (d & 8'hfd) : d;
    sfrWrite = 1'b1;
    @(negedge core_clk);
    sfrWrite = 1'b0;
    // Released data lines must not keep the old value
    sfrWdata = ~sfrWdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrRead = 1'b1;
    #1;
    d = sfrRdata;
    @(negedge core_clk);
    sfrRead = 1'b0;
  endtask
  // Both bytes inside one cycle, so a moving count cannot tear
  task automatic peek16(input logic [7:0] a, output logic [15:0] v);
    sfrAddr = a;
    #1;
    v[7:0] = sfrRdata;
    sfrAddr = a + 8'h01;
    #1;
    v[15:8] = sfrRdata;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the CAN mask, mailbox and timer register slice.
// Assumes the host model drives the register bus; page and frame inputs come from here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import can_regs_pkg::*;
  logic core_clk, resetn, pageWrite, autoIncEnable, frameIsRx, stampStrobe, trigStrobe;
  logic remoteReqTag, extFlagTag, rxRemoteReq, rxExtFlag;
  logic [3:0] pageObject;
  logic [2:0] pageIndex;
  logic [ID_BITS-1:0] idTagBits, rxId;
  wire logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  wire logic sfrWrite, sfrRead, sfrHit, accept, timerTick;
  wire logic [2:0] bytePointer;
  int badCount, cmpCount;
  sfr_host_model host (.core_clk, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata);
  can_mask_mailbox_timers #(.OBJECTS(15)) dut (.core_clk, .resetn, .sfrAddr, .sfrWrite,
    .sfrRead, .sfrWdata, .sfrRdata, .sfrHit, .pageObject, .pageIndex, .pageWrite,
    .autoIncEnable, .idTagBits, .remoteReqTag, .extFlagTag, .rxId, .rxRemoteReq, .rxExtFlag,
    .frameIsRx, .stampStrobe, .trigStrobe, .accept, .bytePointer, .timerTick);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic setPage(input logic [3:0] o, input logic [2:0] i);
    @(negedge core_clk);
    pageObject = o;
    pageIndex = i;
    pageWrite = 1'b1;
    @(negedge core_clk);
    pageWrite = 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic tryMask(input logic [7:0] a, input logic [7:0] m, input logic [28:0] x,
                         input logic rf, input logic ef, input logic exp);
    host.wr(a, m);
    rxId = idTagBits ^ x;
    rxRemoteReq = remoteReqTag ^ rf;
    rxExtFlag = extFlagTag ^ ef;
    #1;
    chk1(accept, exp);
  endtask
  initial begin : guard
    #200000;
    badCount++;
    summarize();
  end
  initial begin : main
    logic [15:0] v, t;
    int n;
    {resetn, pageWrite, autoIncEnable, frameIsRx, stampStrobe, trigStrobe} = 6'h00;
    {remoteReqTag, extFlagTag, rxRemoteReq, rxExtFlag, pageObject, pageIndex} = 11'h7ff;
    idTagBits = 29'h1abcdef1;
    rxId = 29'h1abcdef1;
    repeat (12) @(negedge core_clk);
    host.peek16(ADDR_MSG_TIMER_LOW, v);
    chk(v, TIMER_RESET);
    host.peek16(ADDR_TRIG_CAP_LOW, v);
    chk(v, TIMER_RESET);
    host.peek16(ADDR_TIMER_PRESCALE, v);
    chk(v, {8'h00, PRESCALE_RESET});
    resetn = 1'b1;
    host.wr(ADDR_TIMER_PRESCALE, 8'hff);
    rdChk(ADDR_TIMER_PRESCALE, 8'hff);
    host.wr(8'h30, 8'h5a);
    rdChk(8'h30, 8'h00);
    chk1(sfrHit, 1'b0);
    host.wr(ADDR_TRIG_CAP_LOW, 8'hff);
    rdChk(ADDR_TRIG_CAP_LOW, 8'h00);
    host.wr(ADDR_TIMER_PRESCALE, 8'h03);
    n = 0;
    host.peek16(ADDR_MSG_TIMER_LOW, t);
    repeat (40) begin
      @(negedge core_clk);
      n += int'(timerTick);
    end
    host.peek16(ADDR_MSG_TIMER_LOW, v);
    chk(n[15:0], 16'h000a);
    chk(v - t, 16'h000a);
    setPage(4'h2, 3'h0);
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      trigStrobe = (k == 0);
      stampStrobe = (k == 1);
      host.peek16(ADDR_MSG_TIMER_LOW, t);
      @(negedge core_clk);
      {trigStrobe, stampStrobe} = 2'b00;
      host.wr(k ? ADDR_STAMP_LOW : ADDR_TRIG_CAP_LOW, ~t[7:0]);
      host.peek16(k ? ADDR_STAMP_LOW : ADDR_TRIG_CAP_LOW, v);
      chk(v, t);
    end
    autoIncEnable = 1'b1;
    setPage(4'h3, 3'h6);
    for (int k = 0; k < 3; k++) host.wr(ADDR_MAILBOX_DATA, 8'h10 + 8'(k));
    chk({13'h0, bytePointer}, 16'h0001);
    setPage(4'h4, 3'h6);
    host.wr(ADDR_MAILBOX_DATA, 8'h77);
    setPage(4'h3, 3'h6);
    chk({13'h0, bytePointer}, 16'h0006);
    for (int k = 0; k < 3; k++) rdChk(ADDR_MAILBOX_DATA, 8'h10 + 8'(k));
    autoIncEnable = 1'b0;
    setPage(4'h3, 3'h7);
    rdChk(ADDR_MAILBOX_DATA, 8'h11);
    rdChk(ADDR_MAILBOX_DATA, 8'h11);
    // Masks start undefined, so every one is programmed first
    host.wr(ADDR_ID_MASK_TOP, 8'hff);
    host.wr(ADDR_ID_MASK_MID_HIGH, 8'hff);
    host.wr(ADDR_ID_MASK_MID_LOW, 8'hff);
    rdChk(ADDR_ID_MASK_MID_LOW, 8'hff);
    frameIsRx = 1'b1;
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfd, 29'h0, 1'b0, 1'b0, 1'b1);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfd, 29'h1, 1'b0, 1'b0, 1'b0);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hf5, 29'h1, 1'b0, 1'b0, 1'b1);
    tryMask(ADDR_ID_MASK_TOP, 8'hff, 29'h10000000, 1'b0, 1'b0, 1'b0);
    tryMask(ADDR_ID_MASK_TOP, 8'h7f, 29'h10000000, 1'b0, 1'b0, 1'b1);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfd, 29'h0, 1'b1, 1'b0, 1'b0);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hf9, 29'h0, 1'b1, 1'b0, 1'b1);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfd, 29'h0, 1'b0, 1'b1, 1'b0);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfc, 29'h0, 1'b0, 1'b1, 1'b1);
    rdChk(ADDR_ID_MASK_LOW_FLAGS, 8'hfc);
    frameIsRx = 1'b0;
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'hfd, 29'h0, 1'b0, 1'b0, 1'b0);
    // Fully open mask takes a frame that differs in every field
    frameIsRx = 1'b1;
    host.wr(ADDR_ID_MASK_TOP, 8'h00);
    host.wr(ADDR_ID_MASK_MID_HIGH, 8'h00);
    host.wr(ADDR_ID_MASK_MID_LOW, 8'h00);
    tryMask(ADDR_ID_MASK_LOW_FLAGS, 8'h00, 29'h1fffffff, 1'b1, 1'b1, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
